/* src/intrusion_pkg.sv */
// Register map, field positions and timing constants of the tamper detector.
package intrusion_pkg;
   // ==========================================================
   // Register offsets.
   localparam logic [7:0] EVENT_FLAGS_OFS          = 8'h0F;
   localparam logic [7:0] INTRUSION_CONFIG_ONE_OFS = 8'h14;
   localparam logic [7:0] INTRUSION_CONFIG_TWO_OFS = 8'h15;
   // ==========================================================
   // Field positions in the configuration registers.
   localparam int DETECT_ENABLE_BIT    = 7;
   localparam int IRQ_ENABLE_BIT       = 6;
   localparam int SWITCH_TYPE_BIT      = 5;
   localparam int TRIGGER_POLARITY_BIT = 4;
   localparam int SAMPLE_SELECT_BIT    = 3;
   // Field positions in the flag register.
   localparam int FLAG_ONE_BIT         = 0;
   localparam int FLAG_TWO_BIT         = 1;
   // ==========================================================
   // Reset values.
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [1:0] FLAGS_RESET  = 2'h0;
   // ==========================================================
   // Timing.
   localparam longint CORE_CLK_HZ      = 250_000_000;
   localparam longint SAMPLE_PERIOD_S  = 1;
   localparam longint SAMPLE_CYCLES    = CORE_CLK_HZ * SAMPLE_PERIOD_S;
endpackage

/* src/tamper_detect_unit.sv */
// Two-channel tamper detection unit with its register port.
`timescale 1ns/100ps

// How it works
// - Two independent channels, each with its own pin and own flag.
// - Detect enable one arms a channel; zero stops detection on that channel only.
// - Enabled channel seeing tamper sets its flag at offset 0Fh.
// - Flags are read-only; cleared only by writing detect enable zero.
// - Interrupt enable one drives the shared interrupt output on tamper.
// - On battery, interrupt drives only when alarm-in-backup enable is one.
// - Switch type bit: one normally open, zero normally closed.
// - Polarity one: tamper is pin high; zero: tamper is pin low.
// - Normally closed: sample select picks 1 Hz sampling or continuous.
// - Normally open ignores sample select and monitors continuously.
// - Stopped oscillator forces continuous monitoring.
module tamper_detect_unit #(
   parameter longint SAMPLE_CYCLES = intrusion_pkg::SAMPLE_CYCLES
) (
   // Clock and reset.
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // Tamper pins and supply state.
   input  wire logic       i_intrusion_input_one,
   input  wire logic       i_intrusion_input_two,
   input  wire logic       i_on_battery,
   input  wire logic       i_osc_stopped,
   input  wire logic       i_alarm_in_backup_enable,
   // Register port.
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   // Interrupt pin, open drain, active low.
   output logic            o_irq_n,
   output logic            o_irq_oe
);
   import intrusion_pkg::*;

   // ==========================================================
   // Elaboration check: the divider holds at most 28 bits.
   if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 64'd268435455) begin : g_bad_cycles
      $error("SAMPLE_CYCLES out of range");
   end

   // ==========================================================
   // Pin synchronisers.
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;
   logic [1:0] sup_meta_r;
   logic [1:0] sup_sync_r;
   logic       on_batt;
   logic       osc_stop;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_r <= 2'h0;
         pin_sync_r <= 2'h0;
         sup_meta_r <= 2'h0;
         sup_sync_r <= 2'h0;
      end else begin
         pin_meta_r <= {i_intrusion_input_two, i_intrusion_input_one};
         pin_sync_r <= pin_meta_r;
         sup_meta_r <= {i_osc_stopped, i_on_battery};
         sup_sync_r <= sup_meta_r;
      end
   end
   assign on_batt  = sup_sync_r[0];
   assign osc_stop = sup_sync_r[1];

   // ==========================================================
   // One-second sampling tick.
   logic [27:0] div_r;
   logic [27:0] div_nxt;
   logic        tick_r;
   logic        tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      div_nxt  = div_r + 28'h0000001;
      if (div_r == 28'(SAMPLE_CYCLES - 1)) begin
         div_nxt  = 28'h0000000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         div_r  <= 28'h0000000;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ==========================================================
   // Configuration registers and flags.
   logic [7:0] cfg_r [2];
   logic [7:0] cfg_nxt [2];
   logic [1:0] flag_r;
   logic [1:0] flag_nxt;
   logic [1:0] hit;
   logic [1:0] sampled;
   logic [1:0] clr;
   logic [1:0] en;
   logic       irq_r;
   logic       irq_nxt;
   logic [7:0] rdata_nxt;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         cfg_nxt[c] = cfg_r[c];
         en[c]      = cfg_r[c][DETECT_ENABLE_BIT];
         // Tamper level: pin equals the chosen polarity.
         hit[c] = en[c]
                & (pin_sync_r[c] == cfg_r[c][TRIGGER_POLARITY_BIT]);
         // Only a normally closed channel with a running oscillator samples.
         sampled[c] = ~cfg_r[c][SWITCH_TYPE_BIT]
                    & cfg_r[c][SAMPLE_SELECT_BIT]
                    & ~osc_stop;
         if (sampled[c] && !tick_r) begin
            hit[c] = 1'b0;
         end
      end
      if (i_reg_wr && i_reg_addr == INTRUSION_CONFIG_ONE_OFS) begin
         cfg_nxt[0] = i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == INTRUSION_CONFIG_TWO_OFS) begin
         cfg_nxt[1] = i_reg_wdata;
      end
      for (int c = 0; c < 2; c++) begin
         clr[c] = ~cfg_nxt[c][DETECT_ENABLE_BIT];
      end
      // A tamper seen in the clearing cycle still sets the flag.
      flag_nxt = (flag_r & ~clr) | hit;
      irq_nxt  = |(flag_nxt & {cfg_nxt[1][IRQ_ENABLE_BIT],
                               cfg_nxt[0][IRQ_ENABLE_BIT]})
               & (~on_batt | i_alarm_in_backup_enable);
      case (i_reg_addr)
         EVENT_FLAGS_OFS:          rdata_nxt = {6'h00, flag_r};
         INTRUSION_CONFIG_ONE_OFS: rdata_nxt = cfg_r[0];
         INTRUSION_CONFIG_TWO_OFS: rdata_nxt = cfg_r[1];
         default:                  rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_r[0]    <= CONFIG_RESET;
         cfg_r[1]    <= CONFIG_RESET;
         flag_r      <= FLAGS_RESET;
         irq_r       <= 1'b0;
         o_reg_rdata <= 8'h00;
         o_irq_n     <= 1'b1;
         o_irq_oe    <= 1'b0;
      end else begin
         cfg_r[0]    <= cfg_nxt[0];
         cfg_r[1]    <= cfg_nxt[1];
         flag_r      <= flag_nxt;
         irq_r       <= irq_nxt;
         o_reg_rdata <= rdata_nxt;
         o_irq_n     <= ~irq_nxt;
         o_irq_oe    <= irq_nxt;
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   // Writes of detect enable zero, one bit per channel.
   logic [1:0] dis_wr;
   // Writes of detect enable one, one bit per channel.
   logic [1:0] keep_wr;

   assign dis_wr[0]  = i_reg_wr && i_reg_addr == INTRUSION_CONFIG_ONE_OFS
                     && !i_reg_wdata[DETECT_ENABLE_BIT];
   assign dis_wr[1]  = i_reg_wr && i_reg_addr == INTRUSION_CONFIG_TWO_OFS
                     && !i_reg_wdata[DETECT_ENABLE_BIT];
   assign keep_wr[0] = i_reg_wr && i_reg_addr == INTRUSION_CONFIG_ONE_OFS
                     && i_reg_wdata[DETECT_ENABLE_BIT];
   assign keep_wr[1] = i_reg_wr && i_reg_addr == INTRUSION_CONFIG_TWO_OFS
                     && i_reg_wdata[DETECT_ENABLE_BIT];

   sequence s_disable_wr(logic [7:0] ofs);
      i_reg_wr && i_reg_addr == ofs && !i_reg_wdata[DETECT_ENABLE_BIT];
   endsequence

   sequence s_cfg_wr(logic [7:0] ofs);
      i_reg_wr && i_reg_addr == ofs;
   endsequence

   a_flag_needs_enable: assert property (
      $rose(flag_r[0]) |-> $past(cfg_r[0][DETECT_ENABLE_BIT]))
      else $error("Flag one rose while channel one disabled.");
   a_flag_two_enable: assert property (
      $rose(flag_r[1]) |-> $past(cfg_r[1][DETECT_ENABLE_BIT]))
      else $error("Flag two rose while channel two disabled.");
   a_flag_sets_on_hit: assert property (
      cfg_r[0][DETECT_ENABLE_BIT] && !sampled[0]
      && pin_sync_r[0] == cfg_r[0][TRIGGER_POLARITY_BIT] |=> flag_r[0])
      else $error("Continuous tamper on channel one did not set flag.");
   a_flag_two_sets: assert property (
      cfg_r[1][DETECT_ENABLE_BIT] && !sampled[1]
      && pin_sync_r[1] == cfg_r[1][TRIGGER_POLARITY_BIT] |=> flag_r[1])
      else $error("Continuous tamper on channel two did not set flag.");
   a_flag_holds: assert property (
      flag_r[0] && !dis_wr[0]
      && cfg_r[0][DETECT_ENABLE_BIT] |=> flag_r[0])
      else $error("Flag one cleared without enable write of zero.");
   a_flag_two_holds: assert property (
      flag_r[1] && !dis_wr[1]
      && cfg_r[1][DETECT_ENABLE_BIT] |=> flag_r[1])
      else $error("Flag two cleared without enable write of zero.");
   a_flag_clears: assert property (
      s_disable_wr(INTRUSION_CONFIG_ONE_OFS) |=> !flag_r[0] || $past(hit[0]))
      else $error("Flag one not cleared by enable write of zero.");
   a_flag_two_clears: assert property (
      s_disable_wr(INTRUSION_CONFIG_TWO_OFS) |=> !flag_r[1] || $past(hit[1]))
      else $error("Flag two not cleared by enable write of zero.");
   a_flag_stays_clear: assert property (
      !cfg_r[0][DETECT_ENABLE_BIT] && !keep_wr[0] |=> !flag_r[0])
      else $error("Flag one set while channel one stays disabled.");
   a_flag_two_clear: assert property (
      !cfg_r[1][DETECT_ENABLE_BIT] && !keep_wr[1] |=> !flag_r[1])
      else $error("Flag two set while channel two stays disabled.");
   a_cfg_one_write: assert property (
      s_cfg_wr(INTRUSION_CONFIG_ONE_OFS) |=> cfg_r[0] == $past(i_reg_wdata))
      else $error("Write to configuration one did not land.");
   a_cfg_two_write: assert property (
      s_cfg_wr(INTRUSION_CONFIG_TWO_OFS) |=> cfg_r[1] == $past(i_reg_wdata))
      else $error("Write to configuration two did not land.");
   a_flag_read: assert property (
      i_reg_addr == EVENT_FLAGS_OFS |=> o_reg_rdata == {6'h00, $past(flag_r)})
      else $error("Flag register read back wrong value.");
   a_irq_follows: assert property (
      flag_r[0] && cfg_r[0][IRQ_ENABLE_BIT]
      && $past(!on_batt || i_alarm_in_backup_enable) |-> !o_irq_n)
      else $error("Interrupt not driven for enabled flag one.");
   a_irq_two_follows: assert property (
      flag_r[1] && cfg_r[1][IRQ_ENABLE_BIT]
      && $past(!on_batt || i_alarm_in_backup_enable) |-> !o_irq_n)
      else $error("Interrupt not driven for enabled flag two.");
   a_irq_needs_flag: assert property (
      !o_irq_n |-> (flag_r[0] && cfg_r[0][IRQ_ENABLE_BIT])
                || (flag_r[1] && cfg_r[1][IRQ_ENABLE_BIT]))
      else $error("Interrupt driven with no enabled flag.");
   a_irq_backup: assert property (
      !o_irq_n |-> $past(!on_batt || i_alarm_in_backup_enable))
      else $error("Interrupt driven on battery without backup enable.");
   a_sample_gate: assert property (
      $rose(flag_r[0]) && $past(sampled[0]) |-> $past(tick_r))
      else $error("Sampled channel set its flag off the tick.");
   a_sample_two_gate: assert property (
      $rose(flag_r[1]) && $past(sampled[1]) |-> $past(tick_r))
      else $error("Sampled channel two set its flag off the tick.");
   a_no_open_sample: assert property (
      cfg_r[0][SWITCH_TYPE_BIT] |-> !sampled[0])
      else $error("Normally open channel is sampling.");
   a_no_open_two: assert property (
      cfg_r[1][SWITCH_TYPE_BIT] |-> !sampled[1])
      else $error("Normally open channel two is sampling.");
   a_osc_fallback: assert property (
      osc_stop |-> sampled == 2'h0)
      else $error("Sampling while oscillator stopped.");
   a_irq_oe_pair: assert property (
      o_irq_oe == !o_irq_n)
      else $error("Interrupt enable and level disagree.");
endmodule

/* testbench/tamper_switches.sv */
// External tamper switches that drive the two tamper pins.
`timescale 1ns/100ps
module tamper_switches (
   // Tamper commands and trip direction.
   input  wire logic i_tamper_one,
   input  wire logic i_tamper_two,
   input  wire logic i_pol_one,
   input  wire logic i_pol_two,
   // Pins.
   output logic      o_pin_one,
   output logic      o_pin_two
);
   // A tripped switch takes its pin to the trip level, else the other one.
   assign o_pin_one = i_tamper_one ? i_pol_one : !i_pol_one;
   assign o_pin_two = i_tamper_two ? i_pol_two : !i_pol_two;
endmodule

/* testbench/tamper_detect_unit_bench.sv */
// Self-checking bench of the tamper detection unit.
`timescale 1ns/100ps
module tamper_detect_unit_bench;
   import intrusion_pkg::*;
   logic       clk = 0, rst = 1, wr = 0, bat = 0, osc = 0, abe = 0;
   logic       t1 = 0, t2 = 0, p1 = 1, p2 = 1, pin1, pin2, irq_n, oe;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
   int         bad_count = 0, checks = 0;
   // Rows: config of channel one, expected flags, expected irq level.
   logic [16:0] rows [6] = '{{8'h90, 8'h01, 1'b1}, {8'h10, 8'h00, 1'b1},
      {8'hC0, 8'h01, 1'b0}, {8'hE8, 8'h01, 1'b0},
      {8'hD8, 8'h01, 1'b0}, {8'hD0, 8'h01, 1'b0}};
   always #2 clk = !clk;
   tamper_switches sw_u (.i_tamper_one(t1), .i_tamper_two(t2),
      .i_pol_one(p1), .i_pol_two(p2), .o_pin_one(pin1), .o_pin_two(pin2));
   tamper_detect_unit #(.SAMPLE_CYCLES(16)) dut_u (.i_core_clk(clk),
      .i_rst(rst), .i_intrusion_input_one(pin1),
      .i_intrusion_input_two(pin2), .i_on_battery(bat),
      .i_osc_stopped(osc), .i_alarm_in_backup_enable(abe),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
      .o_reg_rdata(rdata), .o_irq_n(irq_n), .o_irq_oe(oe));
   // ==========================================================
   // Tasks.
   task automatic test_done();
      $display("mismatches %0d of %0d checks", bad_count, checks);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 chk(rdata, exp);
   endtask
   task automatic settle();
      repeat (24) @(posedge clk);
      #1;
   endtask
   task automatic irq(input logic e);
      chk({6'h00, oe, irq_n}, {6'h00, !e, e});
   endtask
   // ==========================================================
   // Watchdog.
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(INTRUSION_CONFIG_ONE_OFS, CONFIG_RESET);
      rd(EVENT_FLAGS_OFS, 8'h00);
      rd(8'h30, 8'h00);
      irq(1'b1);
      foreach (rows[i]) begin
         t1 <= 1'b0;
         p1 <= rows[i][13];
         wrt(INTRUSION_CONFIG_ONE_OFS, 8'h00);
         settle();
         rd(EVENT_FLAGS_OFS, 8'h00);
         wrt(INTRUSION_CONFIG_ONE_OFS, rows[i][16:9]);
         t1 <= 1'b1;
         settle();
         rd(EVENT_FLAGS_OFS, rows[i][8:1]);
         irq(rows[i][0]);
      end
      t1 <= 1'b0;
      wrt(EVENT_FLAGS_OFS, 8'hFF);
      settle();
      rd(EVENT_FLAGS_OFS, 8'h01);
      bat <= 1'b1;
      settle();
      irq(1'b1);
      abe <= 1'b1;
      settle();
      irq(1'b0);
      bat <= 1'b0;
      wrt(INTRUSION_CONFIG_TWO_OFS, 8'h90);
      t2 <= 1'b1;
      settle();
      rd(EVENT_FLAGS_OFS, 8'h03);
      wrt(INTRUSION_CONFIG_ONE_OFS, 8'h00);
      rd(EVENT_FLAGS_OFS, 8'h02);
      rd(INTRUSION_CONFIG_TWO_OFS, 8'h90);
      irq(1'b1);
      // Stopped oscillator: a sampled channel must react at once.
      osc <= 1'b1;
      p1 <= 1'b1;
      wrt(INTRUSION_CONFIG_ONE_OFS, 8'hD8);
      t1 <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rd(EVENT_FLAGS_OFS, 8'h03);
      irq(1'b0);
      // Reset in mid-run clears configuration, flags and interrupt.
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(EVENT_FLAGS_OFS, 8'h00);
      rd(INTRUSION_CONFIG_ONE_OFS, CONFIG_RESET);
      irq(1'b1);
      test_done();
   end
endmodule
